// ==== logic/sysmap_pkg.sv ====
// Function
// - Copy nonvolatile byte into latches at reset
// - Behaviour follows latches; byte change waits reset
// - Reads return latches; programming targets byte
// - EEPROM page field places EEPROM at n800
// - Security bit reads one when option absent
// - Watchdog disabled when latch is one
// - ROM latch zero routes ROM range external
// - Single-chip mode forces ROM enabled
// - EEPROM latch zero removes EEPROM from map
// - Mapping register: once in 64 cycles normal, anytime special
// - RAM page field gives RAM upper digit
// - Register page field gives block upper digit
// - Time-protected option bits write once in normal mode, then read-only
// - Protected option bits: 64 cycles normal, anytime special
// - Affected modes keep watchdog latch; test bit governs
// - Programmed bits reset to last programmed value
// - Special flag latched as inverse mode pin b
package sysmap_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [15:0] OFS_CONFIG = 16'h103f;
  localparam logic [15:0] OFS_PAGE_MAP = 16'h103d;
  localparam logic [15:0] OFS_OPTIONS = 16'h1039;
  localparam logic [15:0] OFS_NV_PROG = 16'h1030;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_EE_LSB = 4;
  localparam int CFG_SEC_BIT = 3;
  localparam int CFG_WDOG_BIT = 2;
  localparam int CFG_ROM_BIT = 1;
  localparam int CFG_EEP_BIT = 0;
  localparam int MAP_RAM_LSB = 4;
  localparam int MAP_REG_LSB = 0;

  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] MAP_RESET = 8'h01;
  localparam logic [7:0] OPT_RESET = 8'h10;
  localparam logic [7:0] OPT_PROT_MASK = 8'h33;
  localparam logic [7:0] OPT_FREE_MASK = 8'hc8;
  localparam logic [7:0] NV_ERASED = 8'hff;
  localparam logic [15:0] EEP_OFFSET = 16'h0800;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int PROT_WINDOW_CYC = 64;
  localparam logic [6:0] PROT_WINDOW = 7'd64;

  // ------------------------------------------------------------
  // Reset sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b100
  } seq_state_t;

  // Upper nibble of an address
  function automatic logic [3:0] page_of(input logic [15:0] a);
    page_of = a[15:12];
  endfunction

endpackage

// ==== logic/nv_config_cell.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Nonvolatile configuration byte model
// ------------------------------------------------------------
module nv_config_cell
  import sysmap_pkg::*;
(
  input wire logic mclk,
  input wire logic prog_we,
  input wire logic [7:0] prog_data,
  output logic [7:0] nv_value
);

  // Power-up content is the erased state; no reset touches the cell
  logic [7:0] cell_q = NV_ERASED;
  logic [7:0] cell_d;

  // Programming only clears bits; erase is outside this block
  always_comb begin
    cell_d = cell_q;
    if (prog_we) begin
      cell_d = cell_q & prog_data;
    end
  end

  // Keeps its value across reset, as a real cell would
  always_ff @(posedge mclk) begin
    cell_q <= cell_d;
  end

  assign nv_value = cell_q;

endmodule

// ==== logic/addr_decoder.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Memory map decode from the live latches
// ------------------------------------------------------------
module addr_decoder
  import sysmap_pkg::*;
(
  input wire logic [15:0] cpu_addr,
  input wire logic [3:0] ram_page,
  input wire logic [3:0] reg_page,
  input wire logic [3:0] eep_page,
  input wire logic rom_on,
  input wire logic eep_on,
  input wire logic page_feature,
  output logic sel_ram,
  output logic sel_regs,
  output logic sel_eeprom,
  output logic sel_rom,
  output logic sel_external
);

  logic [3:0] eep_pg;

  // Registers win over RAM, RAM over EEPROM, EEPROM over ROM
  always_comb begin
    eep_pg = page_feature ? eep_page : 4'h0;
    sel_regs = (page_of(cpu_addr) == reg_page) && (cpu_addr[11:6] == 6'h00);
    sel_ram = !sel_regs && (page_of(cpu_addr) == ram_page)
      && (cpu_addr[11:8] == 4'h0);
    sel_eeprom = !sel_regs && !sel_ram && eep_on && (page_of(cpu_addr) == eep_pg)
      && cpu_addr[11];
    sel_rom = !sel_regs && !sel_ram && !sel_eeprom && rom_on && cpu_addr[15]
      && (cpu_addr[14:13] != 2'b00);
    sel_external = !(sel_regs || sel_ram || sel_eeprom || sel_rom);
  end

endmodule

// ==== logic/system_config_memory_map.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/1ns
// ------------------------------------------------------------
// Startup configuration and memory-map control
// ------------------------------------------------------------
module system_config_memory_map
  import sysmap_pkg::*;
#(
  parameter bit SECURITY_OPTION = 1'b1,
  parameter bit EEPROM_PAGING = 1'b1
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic mode_pin_b,
  input wire logic single_chip,
  input wire logic affected_mode,
  input wire logic watchdog_reset_disable,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [15:0] cpu_addr,
  output logic sel_ram,
  output logic sel_regs,
  output logic sel_eeprom,
  output logic sel_rom,
  output logic sel_external,
  output logic special_mode_flag,
  output logic watchdog_timer_enable,
  output logic security_enable,
  output logic irq_edge_only,
  output logic osc_start_delay,
  output logic [1:0] watchdog_rate
);

  import sysmap_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  seq_state_t state_q, state_d;
  // Power-up values only; these flops have no reset of their own
  logic reset_q = 1'b1;
  logic reset_d;
  logic [7:0] cfg_q = NV_ERASED;
  logic [7:0] cfg_d;
  logic [7:0] map_q, map_d;
  logic [7:0] opt_q, opt_d;
  logic map_done_q, map_done_d;
  logic opt_done_q, opt_done_d;
  logic [6:0] cyc_q, cyc_d;
  logic special_mode_flag_q = 1'b0;
  logic special_mode_flag_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] nv_value;
  logic prog_we;
  logic in_window;
  logic [7:0] cfg_view;

  // Programming writes go to the cell, not the latches
  assign prog_we = wr && (addr == OFS_NV_PROG);

  nv_config_cell u_cell (
    .mclk(mclk),
    .prog_we(prog_we),
    .prog_data(wdata),
    .nv_value(nv_value)
  );

  // ------------------------------------------------------------
  // Reset sequencer and latch load
  // ------------------------------------------------------------
  // Loading one cycle after release keeps async paths out of reset
  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    special_mode_flag_d = special_mode_flag_q;
    reset_d = reset;
    case (state_q)
      ST_RESET: begin
        if (!reset) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        cfg_d = nv_value;
        if (affected_mode) begin
          cfg_d[CFG_WDOG_BIT] = cfg_q[CFG_WDOG_BIT];
        end
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    if (reset_q && !reset) begin
      special_mode_flag_d = !mode_pin_b;
    end
  end

  // cfg_q holds across reset so the watchdog bit can be kept
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
    cfg_q <= cfg_d;
    special_mode_flag_q <= special_mode_flag_d;
    reset_q <= reset_d;
  end

  // ------------------------------------------------------------
  // Protection window counter
  // ------------------------------------------------------------
  assign in_window = (cyc_q < PROT_WINDOW);

  always_comb begin
    cyc_d = cyc_q;
    if (in_window && state_q == ST_RUN) begin
      cyc_d = cyc_q + 7'd1;
    end
  end

  // ------------------------------------------------------------
  // Mapping and option registers
  // ------------------------------------------------------------
  always_comb begin
    map_d = map_q;
    opt_d = opt_q;
    map_done_d = map_done_q;
    opt_done_d = opt_done_q;
    if (wr && addr == OFS_PAGE_MAP) begin
      if (special_mode_flag_q) begin
        map_d = wdata;
      end else if (in_window && !map_done_q) begin
        map_d = wdata;
        map_done_d = 1'b1;
      end
    end
    if (wr && addr == OFS_OPTIONS) begin
      opt_d = (opt_q & ~OPT_FREE_MASK) | (wdata & OPT_FREE_MASK);
      if (special_mode_flag_q) begin
        opt_d = (opt_d & ~OPT_PROT_MASK) | (wdata & OPT_PROT_MASK);
      end else if (in_window && !opt_done_q) begin
        opt_d = (opt_d & ~OPT_PROT_MASK) | (wdata & OPT_PROT_MASK);
        opt_done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      map_q <= MAP_RESET;
      opt_q <= OPT_RESET;
      map_done_q <= 1'b0;
      opt_done_q <= 1'b0;
      cyc_q <= 7'd0;
    end else begin
      map_q <= map_d;
      opt_q <= opt_d;
      map_done_q <= map_done_d;
      opt_done_q <= opt_done_d;
      cyc_q <= cyc_d;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Security bit forced when the option is not built in
  always_comb begin
    cfg_view = cfg_q;
    if (!SECURITY_OPTION) begin
      cfg_view[CFG_SEC_BIT] = 1'b1;
    end
    if (!EEPROM_PAGING) begin
      cfg_view[7:CFG_EE_LSB] = 4'h0;
    end
    rdata_d = 8'h00;
    if (rd) begin
      case (addr)
        OFS_CONFIG: rdata_d = cfg_view;
        OFS_PAGE_MAP: rdata_d = map_q;
        OFS_OPTIONS: rdata_d = opt_q & ~8'h04;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  assign special_mode_flag = special_mode_flag_q;
  // In affected modes the test register bit governs the watchdog
  assign watchdog_timer_enable = affected_mode ? !watchdog_reset_disable
    : !cfg_q[CFG_WDOG_BIT];
  assign security_enable = !cfg_view[CFG_SEC_BIT];
  assign irq_edge_only = opt_q[5];
  assign osc_start_delay = opt_q[4];
  assign watchdog_rate = opt_q[1:0];

  addr_decoder u_dec (
    .cpu_addr(cpu_addr),
    .ram_page(map_q[MAP_RAM_LSB +: 4]),
    .reg_page(map_q[MAP_REG_LSB +: 4]),
    .eep_page(cfg_view[CFG_EE_LSB +: 4]),
    .rom_on(cfg_q[CFG_ROM_BIT] | single_chip),
    .eep_on(cfg_q[CFG_EEP_BIT]),
    .page_feature(EEPROM_PAGING),
    .sel_ram(sel_ram),
    .sel_regs(sel_regs),
    .sel_eeprom(sel_eeprom),
    .sel_rom(sel_rom),
    .sel_external(sel_external)
  );

endmodule

// ==== bench/system_config_memory_map_chk.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port-level checker
// ------------------------------------------------------------
module system_config_memory_map_chk
  import sysmap_pkg::*;
#(
  parameter bit SECURITY_OPTION = 1'b1,
  parameter bit EEPROM_PAGING = 1'b1
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic mode_pin_b,
  input wire logic single_chip,
  input wire logic affected_mode,
  input wire logic watchdog_reset_disable,
  input wire logic [15:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic sel_ram,
  input wire logic sel_regs,
  input wire logic sel_eeprom,
  input wire logic sel_rom,
  input wire logic sel_external,
  input wire logic special_mode_flag,
  input wire logic watchdog_timer_enable,
  input wire logic security_enable,
  input wire logic irq_edge_only,
  input wire logic osc_start_delay,
  input wire logic [1:0] watchdog_rate
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Decoder must always pick one target, never two
  AST_ONE_SEL: assert property (
    $onehot({sel_ram, sel_regs, sel_eeprom, sel_rom, sel_external}))
    else $error("select lines not one-hot");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read");
  // Flag takes its new value on the first edge after release
  AST_SPECIAL_MODE_FLAG_HOLD: assert property (!$past(reset) && !$past(reset, 2)
    |-> $stable(special_mode_flag))
    else $error("special flag moved outside reset");
  AST_ROM_FORCED: assert property (single_chip && cpu_addr >= 16'ha000 |-> !sel_external)
    else $error("single-chip ROM range went external");
  AST_AFFECTED_WDOG: assert property (affected_mode
    |-> watchdog_timer_enable == !watchdog_reset_disable)
    else $error("watchdog not following test bit");
  AST_EEP_OFFSET: assert property (sel_eeprom |-> cpu_addr[11] == 1'b1)
    else $error("eeprom selected below page offset");
  AST_REG_BLOCK: assert property (sel_regs |-> cpu_addr[11:6] == 6'h00)
    else $error("register block wider than 64 bytes");
  AST_OPT_READ: assert property ($past(rd && addr == OFS_OPTIONS) |-> rdata[2] == 1'b0 &&
    rdata[5:4] == {$past(irq_edge_only), $past(osc_start_delay)} &&
    rdata[1:0] == $past(watchdog_rate))
    else $error("options readback differs from outputs");
  // Latches settle a few cycles after release, then stay put
  AST_LATCH_STABLE: assert property (!$past(reset) && !$past(reset, 2) && !$past(reset, 3)
    |-> $stable(security_enable))
    else $error("security latch changed without reset");
  AST_SECURITY_DISABLE_OPT: assert property (!SECURITY_OPTION |-> !security_enable)
    else $error("security enabled without option");
endmodule

bind system_config_memory_map system_config_memory_map_chk #(
  .SECURITY_OPTION(SECURITY_OPTION), .EEPROM_PAGING(EEPROM_PAGING)) chk (.*);

// ==== bench/tb_system_config_memory_map.sv ====
`timescale 1ns/1ns
module tb_system_config_memory_map;
  import sysmap_pkg::*;
  logic mclk, reset, mode_pin_b, single_chip, affected_mode, watchdog_reset_disable;
  logic [15:0] addr, cpu_addr;
  logic [7:0] wdata, rdata, v, o;
  logic wr, rd, special_mode_flag, watchdog_timer_enable, security_enable;
  logic sel_ram, sel_regs, sel_eeprom, sel_rom, sel_external, irq_edge_only, osc_start_delay;
  logic [1:0] watchdog_rate;
  int error_cnt, check_count;
  system_config_memory_map DUT (.mclk(mclk), .reset(reset), .mode_pin_b(mode_pin_b),
    .single_chip(single_chip), .affected_mode(affected_mode),
    .watchdog_reset_disable(watchdog_reset_disable), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .cpu_addr(cpu_addr), .sel_ram(sel_ram), .sel_regs(sel_regs),
    .sel_eeprom(sel_eeprom), .sel_rom(sel_rom), .sel_external(sel_external),
    .special_mode_flag(special_mode_flag), .watchdog_timer_enable(watchdog_timer_enable),
    .security_enable(security_enable), .irq_edge_only(irq_edge_only),
    .osc_start_delay(osc_start_delay), .watchdog_rate(watchdog_rate));
  // ------------------------------------------------------------
  // Clock, checks and bus tasks
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic do_reset(input logic mpb);
    @(posedge mclk);
    reset <= 1'b1;
    mode_pin_b <= mpb;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data live only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask
  // Expected select order: ram, regs, eeprom, rom, external
  task automatic sel_at(input logic [15:0] a, input logic sc, input logic [4:0] exp);
    @(posedge mclk);
    cpu_addr <= a;
    single_chip <= sc;
    @(posedge mclk);
    #1 chk("sel", {3'h0, sel_ram, sel_regs, sel_eeprom, sel_rom, sel_external}, {3'h0, exp});
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Whole run is about 455 cycles; this is generous
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {reset, mode_pin_b, single_chip, affected_mode, watchdog_reset_disable, wr, rd} = 7'h60;
    addr = 16'h0000;
    cpu_addr = 16'h0000;
    wdata = 8'h00;
    v = 8'($urandom(32'h9a08220d));
    do_reset(1'b1);
    chk("special_mode_flag", {7'h0, special_mode_flag}, 8'h00);
    rd_reg(OFS_CONFIG, NV_ERASED);
    chk("sec", {7'h0, security_enable}, 8'h00);
    chk("wdog", {7'h0, watchdog_timer_enable}, 8'h00);
    sel_at(16'h0000, 1'b0, 5'b10000);
    sel_at(16'h1000, 1'b0, 5'b01000);
    wr_reg(OFS_PAGE_MAP, 8'h21);
    sel_at(16'h2000, 1'b0, 5'b10000);
    wr_reg(OFS_PAGE_MAP, 8'h31);
    rd_reg(OFS_PAGE_MAP, 8'h21);
    o = 8'($urandom);
    wr_reg(OFS_OPTIONS, o);
    rd_reg(OFS_OPTIONS, o & 8'hfb);
    wr_reg(OFS_OPTIONS, ~o);
    rd_reg(OFS_OPTIONS, (o & OPT_PROT_MASK) | (~o & OPT_FREE_MASK));
    chk("optpins", {2'h0, irq_edge_only, osc_start_delay, 2'h0, watchdog_rate},
      o & OPT_PROT_MASK);
    rd_reg(16'h1001, 8'h00);
    repeat (100) @(posedge mclk);
    wr_reg(OFS_PAGE_MAP, 8'h45);
    rd_reg(OFS_PAGE_MAP, 8'h21);
    // Page kept in 2..9 so the EEPROM cannot overlap RAM, registers or ROM;
    // watchdog bit stays set so a later clear shows what survives reset
    v = {4'h2 + 4'($urandom_range(7)), 1'($urandom), 1'b1, 2'b01};
    wr_reg(OFS_NV_PROG, v);
    rd_reg(OFS_CONFIG, NV_ERASED);
    do_reset(1'b1);
    rd_reg(OFS_CONFIG, v);
    chk("sec", {7'h0, security_enable}, {7'h0, ~v[3]});
    chk("wdog", {7'h0, watchdog_timer_enable}, {7'h0, ~v[2]});
    sel_at({v[7:4], 12'h800}, 1'b0, 5'b00100);
    sel_at(16'ha000, 1'b0, 5'b00001);
    sel_at(16'ha000, 1'b1, 5'b00010);
    chk("optpins", {2'h0, irq_edge_only, osc_start_delay, 2'h0, watchdog_rate},
      OPT_RESET & OPT_PROT_MASK);
    // Window runs out with no write taken: map and protected option bits must refuse
    repeat (80) @(posedge mclk);
    wr_reg(OFS_PAGE_MAP, 8'h45);
    rd_reg(OFS_PAGE_MAP, MAP_RESET);
    wr_reg(OFS_OPTIONS, ~o);
    rd_reg(OFS_OPTIONS, (OPT_RESET & OPT_PROT_MASK) | (~o & OPT_FREE_MASK));
    wr_reg(OFS_NV_PROG, 8'hfe);
    do_reset(1'b0);
    chk("special_mode_flag", {7'h0, special_mode_flag}, 8'h01);
    sel_at({v[7:4], 12'h800}, 1'b0, 5'b00001);
    repeat (100) @(posedge mclk);
    wr_reg(OFS_PAGE_MAP, 8'h51);
    wr_reg(OFS_PAGE_MAP, 8'h61);
    rd_reg(OFS_PAGE_MAP, 8'h61);
    wr_reg(OFS_OPTIONS, o);
    wr_reg(OFS_OPTIONS, ~o);
    rd_reg(OFS_OPTIONS, ~o & 8'hfb);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      affected_mode <= 1'b1;
      watchdog_reset_disable <= 1'(i);
      @(posedge mclk);
      #1 chk("wdog", {7'h0, watchdog_timer_enable}, {7'h0, ~1'(i)});
    end
    // Clear the watchdog bit in the cell; affected mode keeps the old latch
    wr_reg(OFS_NV_PROG, 8'hfb);
    do_reset(1'b0);
    rd_reg(OFS_CONFIG, v & 8'hfe);
    @(posedge mclk);
    affected_mode <= 1'b0;
    do_reset(1'b0);
    rd_reg(OFS_CONFIG, v & 8'hfa);
    chk("wdog", {7'h0, watchdog_timer_enable}, 8'h01);
    report_and_stop;
  end
endmodule
